/* File: rtl/pflm_monitor.sv */
// fault and warning limit monitor with protective output control
`default_nettype none
module pflm_monitor #(
  parameter int unsigned OT_OFF_CYC = pflm_pkg::OT_OFF_CYCLES,
  parameter int unsigned HICCUP_UNIT_CYC = pflm_pkg::HICCUP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pflm_pkg::pflm_cmd_t cmd,
  input wire logic clear_faults,
  input wire pflm_pkg::pflm_tele_t tele,
  input wire logic init_done,
  input wire logic operation_on,
  input wire logic ctrl_pin,
  output logic [15:0] rd_data,
  output logic cmd_ack,
  output logic cmd_err,
  output logic [6:0] alert_src,
  output logic alert_line_n_out,
  output logic alert_line_n_oe,
  output logic output_enable
);
  import pflm_pkg::*;

  typedef struct packed {
    logic [15:0] oc_warn;
    logic [15:0] ot_flt;
    logic [15:0] ot_warn;
    logic [15:0] ov_flt;
    logic [15:0] ov_warn;
    logic [15:0] uv_warn;
    logic [15:0] uv_flt;
    logic [1:0][7:0] resp;
    logic [2:0] sync;
    logic ctrl_lvl;
    logic en_prev;
    pflm_prot_t [1:0] prot;
    logic [1:0][31:0] timer;
    logic [1:0][6:0] retries;
    logic [1:0] hic;
    logic [6:0] flags;
    logic [15:0] rd_data;
    logic ack;
    logic err;
    logic out_en;
  } pflm_state_t;

  pflm_state_t s_reg;
  pflm_state_t s_next;

  // *****************************************************************
  // compare telemetry against limits
  // *****************************************************************
  logic signed [47:0] iout_f, temp_f, vin_f, uv_eff, uv_off_f, uv_flt_f, uv_floor;
  logic [6:0] exceed;
  logic [1:0] fault;
  logic [1:0] restart_ok;
  logic uv_low;
  logic en_now;
  logic reenable;

  always_comb
  begin
    iout_f = lin_to_fix(tele.iout);
    temp_f = lin_to_fix(tele.temp);
    vin_f = lin_to_fix(tele.vin);
    uv_flt_f = lin_to_fix(s_reg.uv_flt);
    uv_off_f = lin_to_fix(tele.vin_off);
    uv_floor = lin_to_fix(tele.vin_on) - UV_MARGIN;
    uv_eff = (uv_flt_f > uv_off_f) ? uv_flt_f : uv_off_f;
    exceed[0] = iout_f > lin_to_fix(s_reg.oc_warn);
    exceed[1] = init_done && (temp_f > lin_to_fix(s_reg.ot_flt));
    exceed[2] = temp_f > lin_to_fix(s_reg.ot_warn);
    exceed[3] = init_done && (vin_f > lin_to_fix(s_reg.ov_flt));
    exceed[4] = vin_f > lin_to_fix(s_reg.ov_warn);
    exceed[5] = vin_f < lin_to_fix(s_reg.uv_warn);
    exceed[6] = init_done && (vin_f < uv_eff);
    uv_low = exceed[6];
    fault[CH_OT] = exceed[1];
    fault[CH_OV] = exceed[3];
    restart_ok[CH_OT] = temp_f < (lin_to_fix(s_reg.ot_flt) - OT_HYST);
    restart_ok[CH_OV] = vin_f < (lin_to_fix(s_reg.ov_flt) - OV_HYST);
    en_now = operation_on && s_reg.ctrl_lvl;
    reenable = en_now && !s_reg.en_prev;
  end

  // *****************************************************************
  // next state
  // *****************************************************************
  always_comb
  begin
    logic [1:0] mode;
    logic [2:0] rcode;
    logic [2:0] dcode;
    logic signed [47:0] wr_f;
    mode = 2'h0;
    rcode = 3'h0;
    dcode = 3'h0;
    wr_f = '0;
    s_next = s_reg;
    s_next.ack = 1'b0;
    s_next.err = 1'b0;
    s_next.sync = {s_reg.sync[1:0], ctrl_pin};
    if (s_reg.sync[1] == s_reg.sync[2])
      s_next.ctrl_lvl = s_reg.sync[2];
    s_next.en_prev = en_now;

    // command port
    if (cmd.valid)
    begin
      s_next.ack = 1'b1;
      if (cmd.write)
      begin
        case (cmd.code)
          CMD_OC_WARN: s_next.oc_warn = cmd.wdata;
          CMD_OT_FAULT: s_next.ot_flt = cmd.wdata;
          CMD_OT_RESP: s_next.resp[CH_OT] = cmd.wdata[7:0];
          CMD_OT_WARN: s_next.ot_warn = cmd.wdata;
          CMD_OV_FAULT: s_next.ov_flt = cmd.wdata;
          CMD_OV_RESP: s_next.resp[CH_OV] = cmd.wdata[7:0];
          CMD_OV_WARN: s_next.ov_warn = cmd.wdata;
          CMD_UV_WARN: s_next.uv_warn = cmd.wdata;
          CMD_UV_FAULT:
          begin
            wr_f = lin_to_fix(cmd.wdata);
            s_next.uv_flt = (wr_f < uv_floor) ? fix_to_lin(uv_floor) : cmd.wdata;
          end
          default: s_next.err = 1'b1;
        endcase
      end
      else
      begin
        case (cmd.code)
          CMD_OC_WARN: s_next.rd_data = s_reg.oc_warn;
          CMD_OT_FAULT: s_next.rd_data = s_reg.ot_flt;
          CMD_OT_RESP: s_next.rd_data = {8'h00, s_reg.resp[CH_OT]};
          CMD_OT_WARN: s_next.rd_data = s_reg.ot_warn;
          CMD_OV_FAULT: s_next.rd_data = s_reg.ov_flt;
          CMD_OV_RESP: s_next.rd_data = {8'h00, s_reg.resp[CH_OV]};
          CMD_OV_WARN: s_next.rd_data = s_reg.ov_warn;
          CMD_UV_WARN: s_next.rd_data = s_reg.uv_warn;
          CMD_UV_FAULT: s_next.rd_data = s_reg.uv_flt;
          default:
          begin
            s_next.rd_data = 16'h0000;
            s_next.err = 1'b1;
          end
        endcase
      end
    end

    // sticky alert sources, set wins over clear
    if (clear_faults)
      s_next.flags = 7'h00;
    s_next.flags = s_next.flags | exceed;

    // protection per channel
    for (int i = 0; i < 2; i++)
    begin
      mode = s_reg.resp[i][RESP_MODE_HI:RESP_MODE_LO];
      rcode = s_reg.resp[i][RESP_RETRY_HI:RESP_RETRY_LO];
      dcode = s_reg.resp[i][RESP_DELAY_HI:RESP_DELAY_LO];
      case (s_reg.prot[i])
        PROT_RUN:
        begin
          if (!fault[i])
            s_next.hic[i] = 1'b0;
          else if (mode == MODE_OFF)
          begin
            s_next.prot[i] = PROT_WAIT;
            s_next.timer[i] = (i == CH_OT) ? 32'(OT_OFF_CYC) : 32'h0000_0000;
          end
          else if (mode == MODE_HICCUP)
          begin
            s_next.prot[i] = PROT_WAIT;
            s_next.timer[i] = 32'(HICCUP_UNIT_CYC) << dcode;
            s_next.hic[i] = 1'b1;
            if (!s_reg.hic[i])
              s_next.retries[i] = 7'h01 << rcode;
          end
        end
        PROT_WAIT:
        begin
          if (s_reg.timer[i] != 32'h0000_0000)
            s_next.timer[i] = s_reg.timer[i] - 32'h0000_0001;
          else
            s_next.prot[i] = PROT_HOLD;
        end
        PROT_HOLD:
        begin
          if (mode == MODE_HICCUP)
          begin
            if (rcode == RETRY_FOREVER)
              s_next.prot[i] = PROT_RUN;
            else if (s_reg.retries[i] == 7'h00)
              s_next.prot[i] = PROT_LATCH;
            else
            begin
              s_next.retries[i] = s_reg.retries[i] - 7'h01;
              s_next.prot[i] = PROT_RUN;
            end
          end
          else if (restart_ok[i])
            s_next.prot[i] = PROT_RUN;
        end
        PROT_LATCH: s_next.prot[i] = PROT_LATCH;
        default: s_next.prot[i] = PROT_RUN;
      endcase
      if (reenable && s_reg.prot[i] != PROT_RUN)
      begin
        s_next.prot[i] = PROT_RUN;
        s_next.hic[i] = 1'b0;
      end
    end

    s_next.out_en = en_now && !uv_low && (s_next.prot[CH_OT] == PROT_RUN)
      && (s_next.prot[CH_OV] == PROT_RUN);
  end

  // *****************************************************************
  // state register
  // *****************************************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_reg.oc_warn <= RST_OVER_LIMIT;
      s_reg.ot_flt <= RST_OVER_LIMIT;
      s_reg.ot_warn <= RST_OVER_LIMIT;
      s_reg.ov_flt <= RST_OVER_LIMIT;
      s_reg.ov_warn <= RST_OVER_LIMIT;
      s_reg.uv_warn <= RST_UNDER_LIMIT;
      s_reg.uv_flt <= RST_UNDER_LIMIT;
      s_reg.resp <= {RST_RESP, RST_RESP};
      s_reg.sync <= 3'h0;
      s_reg.ctrl_lvl <= 1'b0;
      s_reg.en_prev <= 1'b0;
      s_reg.prot[0] <= PROT_RUN;
      s_reg.prot[1] <= PROT_RUN;
      s_reg.timer <= '0;
      s_reg.retries <= '0;
      s_reg.hic <= 2'h0;
      s_reg.flags <= 7'h00;
      s_reg.rd_data <= 16'h0000;
      s_reg.ack <= 1'b0;
      s_reg.err <= 1'b0;
      s_reg.out_en <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  // *****************************************************************
  // outputs
  // *****************************************************************
  assign rd_data = s_reg.rd_data;
  assign cmd_ack = s_reg.ack;
  assign cmd_err = s_reg.err;
  assign alert_src = s_reg.flags;
  assign alert_line_n_out = 1'b0;
  assign alert_line_n_oe = |s_reg.flags;
  assign output_enable = s_reg.out_en;
endmodule
`default_nettype wire

/* File: include/pflm_pkg.sv */
// constants, types and shared helpers of the fault limit monitor
`default_nettype none
// *****************************************************************
// *****************************************************************
package pflm_pkg;
  localparam logic [7:0] CMD_OC_WARN = 8'h4A;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] CMD_OT_RESP = 8'h50;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_OV_RESP = 8'h56;
  localparam logic [7:0] CMD_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_UV_FAULT = 8'h59;
  localparam logic [15:0] RST_OVER_LIMIT = 16'h03FF;
  localparam logic [15:0] RST_UNDER_LIMIT = 16'h0000;
  localparam logic [7:0] RST_RESP = 8'hC0;
  localparam int RESP_MODE_HI = 7;
  localparam int RESP_MODE_LO = 6;
  localparam int RESP_RETRY_HI = 5;
  localparam int RESP_RETRY_LO = 3;
  localparam int RESP_DELAY_HI = 2;
  localparam int RESP_DELAY_LO = 0;
  localparam logic [1:0] MODE_HICCUP = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int CLK_KHZ = 200000;
  localparam int OT_OFF_MS = 3000;
  localparam int HICCUP_UNIT_MS = 100;
  localparam int OT_OFF_CYCLES = OT_OFF_MS * CLK_KHZ;
  localparam int HICCUP_UNIT_CYCLES = HICCUP_UNIT_MS * CLK_KHZ;
  // fixed point: 16 fraction bits
  localparam logic signed [47:0] OT_HYST = 48'sh0000_0005_0000;
  localparam logic signed [47:0] OV_HYST = 48'sh0000_0005_0000;
  localparam logic signed [47:0] UV_MARGIN = 48'sh0000_0002_0000;
  localparam logic [4:0] STORE_EXP = 5'h1C;
  localparam int CH_OT = 0;
  localparam int CH_OV = 1;

  typedef enum logic [3:0] {
    PROT_RUN = 4'h1, PROT_WAIT = 4'h2, PROT_HOLD = 4'h4, PROT_LATCH = 4'h8
  } pflm_prot_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } pflm_cmd_t;

  typedef struct packed {
    logic [15:0] iout;
    logic [15:0] temp;
    logic [15:0] vin;
    logic [15:0] vin_on;
    logic [15:0] vin_off;
  } pflm_tele_t;

  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] s;
    m = 48'(signed'(w[10:0]));
    s = w[15:11] + 5'h10;
    return m <<< s;
  endfunction

  function automatic logic [15:0] fix_to_lin(input logic signed [47:0] f);
    logic signed [47:0] m;
    m = f >>> 12;
    if (m > 48'sd1023)
      m = 48'sd1023;
    else if (m < -48'sd1024)
      m = -48'sd1024;
    return {STORE_EXP, m[10:0]};
  endfunction
endpackage
`default_nettype wire

/* File: testbench/pflm_host_model.sv */
// host controller model issuing management commands
`default_nettype none
module pflm_host_model (
  input wire logic clk,
  output var pflm_pkg::pflm_cmd_t cmd,
  output var logic clear_faults
);
  timeunit 1ns;
  timeprecision 1ps;
  import pflm_pkg::*;
  initial
  begin
    cmd = '0;
    clear_faults = 1'b0;
  end
  // one unit per command, idle bus scrambled
  task automatic send(input logic wr, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cmd <= '{1'b1, wr, c, d};
    @(posedge clk);
    cmd <= '{1'b0, ~wr, ~c, ~d};
  endtask
  task automatic clr;
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/pflm_monitor_chk.sv */
// assertions on the fault limit monitor ports
`default_nettype none
module pflm_monitor_chk #(
  parameter int unsigned OT_OFF_CYC = 20,
  parameter int unsigned HICCUP_UNIT_CYC = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pflm_pkg::pflm_cmd_t cmd,
  input wire logic clear_faults,
  input wire pflm_pkg::pflm_tele_t tele,
  input wire logic init_done,
  input wire logic operation_on,
  input wire logic ctrl_pin,
  input wire logic [15:0] rd_data,
  input wire logic cmd_ack,
  input wire logic cmd_err,
  input wire logic [6:0] alert_src,
  input wire logic alert_line_n_out,
  input wire logic alert_line_n_oe,
  input wire logic output_enable
);
  import pflm_pkg::*;
  wire logic known = cmd.code inside {CMD_OC_WARN, CMD_OT_FAULT, CMD_OT_RESP,
    CMD_OT_WARN, CMD_OV_FAULT, CMD_OV_RESP, CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT};
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_req;
    cmd.valid;
  endsequence
  sequence s_idle_req;
    !cmd.valid;
  endsequence
  a_ack_follows: assert property (s_req |=> cmd_ack) else $error("no ack");
  a_no_stray: assert property (s_idle_req |=> !cmd_ack) else $error("stray ack");
  a_err_code: assert property (s_req |=> cmd_err == !$past(known))
    else $error("bad err");
  a_err_ack: assert property (cmd_err |-> cmd_ack) else $error("err alone");
  a_alert_pull: assert property (alert_line_n_oe == (|alert_src) && !alert_line_n_out)
    else $error("alert line mismatch");
  a_alert_sticky: assert property (!clear_faults |=>
    (alert_src & $past(alert_src)) == $past(alert_src)) else $error("alert lost");
  a_ot_init: assert property ($rose(alert_src[1]) |-> $past(init_done))
    else $error("ot early");
  a_ov_init: assert property ($rose(alert_src[3]) |-> $past(init_done))
    else $error("ov early");
  a_uv_init: assert property ($rose(alert_src[6]) |-> $past(init_done))
    else $error("uv early");
  a_out_needs_op: assert property (output_enable |-> $past(operation_on))
    else $error("output on without enable");
endmodule
bind pflm_monitor pflm_monitor_chk #(.OT_OFF_CYC(OT_OFF_CYC),
  .HICCUP_UNIT_CYC(HICCUP_UNIT_CYC)) pflm_monitor_chk_i (.clk(clk), .nrst(nrst),
  .cmd(cmd), .clear_faults(clear_faults), .tele(tele), .init_done(init_done),
  .operation_on(operation_on), .ctrl_pin(ctrl_pin), .rd_data(rd_data),
  .cmd_ack(cmd_ack), .cmd_err(cmd_err), .alert_src(alert_src),
  .alert_line_n_out(alert_line_n_out), .alert_line_n_oe(alert_line_n_oe),
  .output_enable(output_enable));
`default_nettype wire

/* File: testbench/tb.sv */
// testbench of the fault limit monitor
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pflm_pkg::*;
  logic clk, nrst, init_done, operation_on, ctrl_pin, cmd_ack, cmd_err, clear_faults;
  logic alert_line_n_out, alert_line_n_oe, output_enable;
  logic [15:0] rd_data, voff, r;
  logic [6:0] alert_src;
  logic [17:0] e;
  logic [17:0] exp_q[$];
  logic [31:0] rnd = 32'h500F34FF;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  pflm_cmd_t cmd;
  pflm_tele_t tele;
  logic [7:0] codes[9] = '{CMD_OC_WARN, CMD_OT_FAULT, CMD_OT_RESP, CMD_OT_WARN,
    CMD_OV_FAULT, CMD_OV_RESP, CMD_OV_WARN, CMD_UV_WARN, CMD_UV_FAULT};
  logic [15:0] lim[9] = '{16'h0014, 16'h0064, 16'h00C0, 16'h0050, 16'h003C,
    16'h00C0, 16'h0037, 16'h002A, 16'h0026};
  logic [15:0] rstv[9] = '{RST_OVER_LIMIT, RST_OVER_LIMIT, {8'h00, RST_RESP},
    RST_OVER_LIMIT, RST_OVER_LIMIT, {8'h00, RST_RESP}, RST_OVER_LIMIT,
    RST_UNDER_LIMIT, RST_UNDER_LIMIT};
  // {flags, init, iout, temp, vin}
  logic [31:0] al[10] = '{32'h080A6530, 32'h200A193D, 32'h400A1925, 32'h03151930,
    32'h0D0A6530, 32'h090A5130, 32'h310A193D, 32'h210A1938, 32'h410A1929, 32'hC10A1925};
  pflm_host_model pflm_host_model_i (.clk(clk), .cmd(cmd), .clear_faults(clear_faults));
  pflm_monitor #(.OT_OFF_CYC(20), .HICCUP_UNIT_CYC(4)) pflm_monitor_i (.clk(clk),
    .nrst(nrst), .cmd(cmd), .clear_faults(clear_faults), .tele(tele),
    .init_done(init_done), .operation_on(operation_on), .ctrl_pin(ctrl_pin),
    .rd_data(rd_data), .cmd_ack(cmd_ack), .cmd_err(cmd_err), .alert_src(alert_src),
    .alert_line_n_out(alert_line_n_out), .alert_line_n_oe(alert_line_n_oe),
    .output_enable(output_enable));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic cmp(input string n, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [15:0] d,
    input logic [15:0] x);
    rnd = lfsr(rnd);
    exp_q.push_back({!wr, !(c inside {codes}), x});
    pflm_host_model_i.send(wr, c, wr ? d : rnd[15:0]);
  endtask
  task automatic tset(input logic [7:0] i, input logic [7:0] t, input logic [7:0] v);
    @(posedge clk);
    tele <= '{{8'h00, i}, {8'h00, t}, {8'h00, v}, 16'h0028, voff};
  endtask
  task automatic pstep(input logic op, input logic [7:0] t, input logic [7:0] v,
    input int n, input logic x);
    tset(8'h0A, t, v);
    operation_on <= op;
    repeat (n) @(posedge clk);
    #1 cmp("output_enable", {15'h0, x}, {15'h0, output_enable});
  endtask
  // answers matched oldest first
  always @(posedge clk)
    if (cmd_ack === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp("cmd_ack", 16'h0000, 16'h0001);
      else
      begin
        e = exp_q.pop_front();
        cmp("cmd_err", {15'h0, e[16]}, {15'h0, cmd_err});
        if (e[17])
          cmp("rd_data", e[15:0], rd_data);
      end
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      give_verdict;
    end
  end
  initial
  begin
    nrst = 1'b0;
    init_done = 1'b0;
    operation_on = 1'b0;
    ctrl_pin = 1'b0;
    voff = 16'h001E;
    tele = '{16'h000A, 16'h0019, 16'h0030, 16'h0028, 16'h001E};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 9; i++)
      xfer(1'b0, codes[i], 16'h0000, rstv[i]);
    xfer(1'b0, 8'h4B, 16'h0000, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      r = rnd[15:0];
      xfer(1'b1, codes[i], r, 16'h0000);
      xfer(1'b0, codes[i], 16'h0000, (i == 2 || i == 5) ? {8'h00, r[7:0]} : r);
    end
    xfer(1'b1, CMD_UV_FAULT, 16'h0005, 16'h0000);
    xfer(1'b0, CMD_UV_FAULT, 16'h0000, 16'hE260);
    for (int i = 0; i < 9; i++)
    begin
      xfer(1'b1, codes[i], lim[i], 16'h0000);
      xfer(1'b0, codes[i], 16'h0000, lim[i]);
    end
    // drop warnings left over from the random limit writes
    pflm_host_model_i.clr();
    for (int i = 0; i < 10; i++)
    begin
      tset(al[i][23:16], al[i][15:8], al[i][7:0]);
      init_done <= al[i][24];
      repeat (2) @(posedge clk);
      #1 cmp("alert_src", {9'h0, al[i][31:25]}, {9'h0, alert_src});
      cmp("alert_oe", 16'h0001, {15'h0, alert_line_n_oe});
      tset(8'h0A, 8'h19, 8'h30);
      pflm_host_model_i.clr();
      repeat (2) @(posedge clk);
      #1 cmp("alert_src", 16'h0000, {9'h0, alert_src});
    end
    ctrl_pin <= 1'b1;
    pstep(1'b1, 8'h19, 8'h30, 8, 1'b1);
    pstep(1'b1, 8'h65, 8'h30, 3, 1'b0);
    pstep(1'b1, 8'h60, 8'h30, 30, 1'b0);
    pstep(1'b1, 8'h5E, 8'h30, 4, 1'b1);
    pstep(1'b1, 8'h65, 8'h30, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 9, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 16, 1'b1);
    pstep(1'b1, 8'h65, 8'h30, 3, 1'b0);
    pstep(1'b0, 8'h19, 8'h30, 2, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 4, 1'b1);
    pstep(1'b1, 8'h19, 8'h3D, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h38, 10, 1'b0);
    pstep(1'b1, 8'h19, 8'h36, 4, 1'b1);
    voff = 16'h002D;
    pstep(1'b1, 8'h19, 8'h2C, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 3, 1'b1);
    voff = 16'h001E;
    pstep(1'b1, 8'h19, 8'h25, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 3, 1'b1);
    xfer(1'b1, CMD_OT_RESP, 16'h0081, 16'h0000);
    pstep(1'b1, 8'h65, 8'h30, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 3, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 8, 1'b1);
    // fault persists past the single retry, so the channel latches
    pstep(1'b1, 8'h65, 8'h30, 30, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 12, 1'b0);
    pstep(1'b0, 8'h19, 8'h30, 2, 1'b0);
    pstep(1'b1, 8'h19, 8'h30, 4, 1'b1);
    cmp("pending_acks", 16'h0000, 16'(exp_q.size()));
    give_verdict;
  end
endmodule
`default_nettype wire
